// File: logic/fh_top.v
// Host controller that drives a 16x5 asynchronous FIFO device via its pins.
// Assumes an Avalon-MM master with waitrequest and device pins asynchronous.
`timescale 1ns/10ps
`include "fh_regs.vh"
module fh_top (
  input wire mclk_i,                      // 100 MHz clock
  input wire srst_i,                      // Synchronous reset, high
  input wire [2:0] avs_address_i,         // Word address
  input wire avs_read_i,                  // Read request
  input wire avs_write_i,                 // Write request
  input wire [31:0] avs_writedata_i,      // Write data
  output wire [31:0] avs_readdata_o,      // Read data
  output wire avs_waitrequest_o,          // Stall
  output wire load_clock_first_o,         // Load clock, pulsed
  output wire load_clock_second_o,        // Load clock, tied high or gate
  output wire [4:0] write_data_bit_o,     // Data to device
  output wire unload_clock_in_o,          // Unload clock, idle high
  output wire clear_n_o,                  // Clear, active low
  output wire output_enable_n_o,          // Device output enable, low
  input wire input_ready_i,               // Room available
  input wire output_ready_i,              // Word at output
  input wire last_slot_vacant_pulse_i,    // Low pulse, last slot vacant
  input wire [4:0] read_data_bit_i        // Data from device
);

  // ----------------------------------------
  // Cycle counts
  // ----------------------------------------
  localparam integer N_LD_SETUP = `FH_CYC(`FH_LD_SETUP_NS);
  localparam integer N_LD_HIGH = `FH_CYC(`FH_LD_HIGH_NS);
  localparam integer N_LD_HOLD = `FH_CYC(`FH_LD_HOLD_NS);
  localparam integer N_OE_EN = `FH_CYC(`FH_OE_EN_NS);
  localparam integer N_UN_LOW = `FH_CYC(`FH_UN_LOW_NS);
  localparam integer N_CLR_LOW = `FH_CYC(`FH_CLR_LOW_NS);
  localparam integer N_CLR_REC = `FH_CYC(`FH_CLR_REC_NS);
  localparam integer N_SETTLE = `FH_CYC(`FH_SETTLE_NS);
  localparam [5:0] C_LD_SETUP = N_LD_SETUP[5:0];
  localparam [5:0] C_LD_HIGH = N_LD_HIGH[5:0];
  localparam [5:0] C_LD_HOLD = N_LD_HOLD[5:0];
  localparam [5:0] C_OE_EN = N_OE_EN[5:0];
  localparam [5:0] C_UN_LOW = N_UN_LOW[5:0];
  localparam [5:0] C_CLR_LOW = N_CLR_LOW[5:0];
  localparam [5:0] C_CLR_REC = N_CLR_REC[5:0];
  localparam [5:0] C_SETTLE = N_SETTLE[5:0];

  // ----------------------------------------
  // One-hot states
  // ----------------------------------------
  localparam [8:0] S_IDLE = 9'h001;
  localparam [8:0] S_LD_SETUP = 9'h002;
  localparam [8:0] S_LD_HIGH = 9'h004;
  localparam [8:0] S_LD_HOLD = 9'h008;
  localparam [8:0] S_UN_EN = 9'h010;
  localparam [8:0] S_UN_LOW = 9'h020;
  localparam [8:0] S_CL_LOW = 9'h040;
  localparam [8:0] S_CL_REC = 9'h080;
  localparam [8:0] S_SETTLE = 9'h100;

  reg [8:0] state_q;           // Current state
  reg [5:0] cnt_q;             // Cycles left in state
  reg ctrl_gated_q;            // Gated load mode
  reg [4:0] wdata_q;           // Word driven to device
  reg [4:0] rdata_q;           // Last popped word
  reg vacant_q;                // Sticky last-slot-vacant seen
  reg refused_q;               // Sticky refused command
  reg ack_q;                   // Bus answer cycle
  reg [31:0] readdata_q;       // Registered read data
  reg vac_prev_q;              // Previous vacant level
  wire [7:0] sync_w;           // Synchronised pins
  wire in_ready_s;             // Synced input ready
  wire out_ready_s;            // Synced output ready
  wire vacant_s;               // Synced vacant pulse level
  wire [4:0] rdata_s;          // Synced read data
  wire busy;                   // Pin sequence in progress
  wire req;                    // Any bus request
  wire cmd_wr;                 // Write that starts a sequence
  wire accept;                 // Request answered next cycle
  wire wr_fire;                // Write takes effect now
  wire vac_fall;               // Vacant pulse detected

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  fh_sync #(
    .W(8)
  ) u_sync (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .async_i({read_data_bit_i, last_slot_vacant_pulse_i, output_ready_i, input_ready_i}),
    .sync_o(sync_w)
  );

  assign in_ready_s = sync_w[0];
  assign out_ready_s = sync_w[1];
  assign vacant_s = sync_w[2];
  assign rdata_s = sync_w[7:3];

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  assign busy = (state_q != S_IDLE);
  assign req = avs_read_i | avs_write_i;
  assign cmd_wr = avs_write_i & ((avs_address_i == `FH_REG_WDATA) | (avs_address_i == `FH_REG_CMD));
  assign accept = req & ~ack_q & ~(cmd_wr & busy);
  assign wr_fire = avs_write_i & ack_q;
  assign avs_waitrequest_o = req & ~ack_q;
  assign avs_readdata_o = readdata_q;
  assign vac_fall = vac_prev_q & ~vacant_s;

  // Answer flop and read data capture
  always @(posedge mclk_i) begin
    if (srst_i) begin
      ack_q <= 1'b0;
      readdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= accept;
      if (accept & avs_read_i) begin
        case (avs_address_i)
          `FH_REG_CTRL: readdata_q <= {31'h0000_0000, ctrl_gated_q};
          `FH_REG_WDATA: readdata_q <= {27'h000_0000, wdata_q};
          `FH_REG_RDATA: readdata_q <= {27'h000_0000, rdata_q};
          `FH_REG_STATUS: readdata_q <= {27'h000_0000, refused_q, vacant_q, out_ready_s, in_ready_s, busy};
          default: readdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Control register and sticky vacant flag
  // ----------------------------------------
  always @(posedge mclk_i) begin
    if (srst_i) begin
      ctrl_gated_q <= 1'b0;
      vacant_q <= 1'b0;
      vac_prev_q <= 1'b0; // Same as synchroniser reset, so no false edge
    end else begin
      vac_prev_q <= vacant_s;
      // Mode select
      if (wr_fire & (avs_address_i == `FH_REG_CTRL)) begin
        ctrl_gated_q <= avs_writedata_i[`FH_CTRL_GATED];
      end
      // Set wins over write-one-to-clear
      if (vac_fall) begin
        vacant_q <= 1'b1;
      end else if (wr_fire & (avs_address_i == `FH_REG_STATUS) & avs_writedata_i[`FH_ST_VACANT]) begin
        vacant_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Pin sequencer
  // ----------------------------------------
  always @(posedge mclk_i) begin
    if (srst_i) begin
      state_q <= S_IDLE;
      cnt_q <= 6'h00;
      wdata_q <= 5'h00;
      rdata_q <= 5'h00;
      refused_q <= 1'b0;
    end else begin
      // Refusal flag clear; set below wins
      if (wr_fire & (avs_address_i == `FH_REG_STATUS) & avs_writedata_i[`FH_ST_REFUSED]) begin
        refused_q <= 1'b0;
      end
      if (cnt_q != 6'h00) begin
        cnt_q <= cnt_q - 6'h01;
      end
      case (state_q)
        S_IDLE: begin
          // Push a word
          if (wr_fire & (avs_address_i == `FH_REG_WDATA)) begin
            if (in_ready_s) begin
              wdata_q <= avs_writedata_i[4:0];
              state_q <= S_LD_SETUP;
              cnt_q <= C_LD_SETUP;
            end else begin
              refused_q <= 1'b1;
            end
          end else if (wr_fire & (avs_address_i == `FH_REG_CMD)) begin
            // Clear takes priority over pop
            if (avs_writedata_i[`FH_CMD_CLEAR]) begin
              state_q <= S_CL_LOW;
              cnt_q <= C_CLR_LOW;
            end else if (avs_writedata_i[`FH_CMD_POP]) begin
              if (out_ready_s) begin
                state_q <= S_UN_EN;
                cnt_q <= C_OE_EN;
              end else begin
                refused_q <= 1'b1;
              end
            end
          end
        end
        S_LD_SETUP: begin
          // Data and gate settle before the edge
          if (cnt_q == 6'h00) begin
            state_q <= S_LD_HIGH;
            cnt_q <= C_LD_HIGH;
          end
        end
        S_LD_HIGH: begin
          // Clock high; rising edge loads
          if (cnt_q == 6'h00) begin
            state_q <= S_LD_HOLD;
            cnt_q <= C_LD_HOLD;
          end
        end
        S_LD_HOLD: begin
          // Hold data after the edge
          if (cnt_q == 6'h00) begin
            state_q <= S_SETTLE;
            cnt_q <= C_SETTLE;
          end
        end
        S_UN_EN: begin
          // Outputs enabled; capture word at end
          if (cnt_q == 6'h00) begin
            rdata_q <= rdata_s;
            state_q <= S_UN_LOW;
            cnt_q <= C_UN_LOW;
          end
        end
        S_UN_LOW: begin
          // Unload low; release gives the pop edge
          if (cnt_q == 6'h00) begin
            state_q <= S_SETTLE;
            cnt_q <= C_SETTLE;
          end
        end
        S_CL_LOW: begin
          // Clear held low
          if (cnt_q == 6'h00) begin
            state_q <= S_CL_REC;
            cnt_q <= C_CLR_REC;
          end
        end
        S_CL_REC: begin
          // Recovery before the next load
          if (cnt_q == 6'h00) begin
            state_q <= S_SETTLE;
            cnt_q <= C_SETTLE;
          end
        end
        S_SETTLE: begin
          // Let status pins update and ripple
          if (cnt_q == 6'h00) begin
            state_q <= S_IDLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
          cnt_q <= 6'h00;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  // Pulsed clock on the first input, gate or tie on the second
  // Pulses in both modes; a tied-high clock would never load
  assign load_clock_first_o = (state_q == S_LD_HIGH);
  assign load_clock_second_o = ctrl_gated_q ?
    ((state_q == S_LD_SETUP) | (state_q == S_LD_HIGH) | (state_q == S_LD_HOLD)) :
    1'b1;
  assign write_data_bit_o = wdata_q;
  assign unload_clock_in_o = (state_q != S_UN_LOW);
  assign clear_n_o = (state_q != S_CL_LOW);
  assign output_enable_n_o = ~((state_q == S_UN_EN) | (state_q == S_UN_LOW));

endmodule

// File: logic/fh_regs.vh
// Constants for the FIFO host controller: register map, fields, timing.
// Assumes a 100 MHz controller clock; included by bare name.
`ifndef FH_REGS_VH
`define FH_REGS_VH

// ----------------------------------------
// Register word indices (Avalon word address)
// ----------------------------------------
`define FH_REG_CTRL    3'h0
`define FH_REG_WDATA   3'h1
`define FH_REG_CMD     3'h2
`define FH_REG_RDATA   3'h3
`define FH_REG_STATUS  3'h4

// ----------------------------------------
// Field positions, word width and depth
// ----------------------------------------
`define FH_CTRL_GATED    0
`define FH_CMD_POP       0
`define FH_CMD_CLEAR     1
`define FH_ST_BUSY       0
`define FH_ST_IN_READY   1
`define FH_ST_OUT_READY  2
`define FH_ST_VACANT     3
`define FH_ST_REFUSED    4
`define FH_WORD_W        5
`define FH_DEPTH         16

// ----------------------------------------
// Timing, in ns, and cycle counts
// ----------------------------------------
`define FH_CLK_NS        10
`define FH_LD_SETUP_NS   10
`define FH_LD_HIGH_NS    25
`define FH_LD_HOLD_NS    70
`define FH_OE_EN_NS      40
`define FH_UN_LOW_NS     25
`define FH_CLR_LOW_NS    40
`define FH_CLR_REC_NS    25
`define FH_SETTLE_NS     400
`define FH_CYC(ns)       (((ns) + `FH_CLK_NS - 1) / `FH_CLK_NS)

`endif

// File: logic/fh_sync.v
// Two-flop synchroniser bank for the device's status and data pins.
// Assumes the inputs are asynchronous to mclk_i.
`timescale 1ns/10ps
module fh_sync #(
  parameter W = 8
) (
  input wire mclk_i,          // Controller clock
  input wire srst_i,          // Synchronous reset
  input wire [W-1:0] async_i, // Raw pins
  output wire [W-1:0] sync_o  // Synchronised pins
);

  reg [W-1:0] meta_q; // First stage, read only by second
  reg [W-1:0] sync_q; // Second stage

  // ----------------------------------------
  // One double-flop per bit
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      // Two flops in series
      always @(posedge mclk_i) begin
        if (srst_i) begin
          meta_q[g] <= 1'b0;
          sync_q[g] <= 1'b0;
        end else begin
          meta_q[g] <= async_i[g];
          sync_q[g] <= meta_q[g];
        end
      end
    end
  endgenerate

  assign sync_o = sync_q;

endmodule

// File: tb/fh_top_chk.sv
// Concurrent checks on the pins of the FIFO host controller.
// Assumes it is bound onto fh_top and that every pin is timed by mclk_i.
`timescale 1ns/10ps
module fh_top_chk (
  input wire mclk_i,                // Controller clock
  input wire srst_i,                // Synchronous reset
  input wire avs_read_i,            // Read request
  input wire avs_write_i,           // Write request
  input wire avs_waitrequest_o,     // Bus stall
  input wire load_clock_first_o,    // Load clock
  input wire load_clock_second_o,   // Load gate
  input wire [4:0] write_data_bit_o, // Word to device
  input wire unload_clock_in_o,     // Unload clock
  input wire clear_n_o,             // Clear, low
  input wire output_enable_n_o      // Output enable, low
);
  // ----------------------------------------
  // Clocking and reset
  // ----------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  // ----------------------------------------
  // Pin sequencing
  // ----------------------------------------
  rst_idle_a: assert property ($fell(srst_i) |-> unload_clock_in_o && clear_n_o && output_enable_n_o)
    else $error("pins not idle after reset");
  wait_idle_a: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
    else $error("stall without request");
  wait_bound_a: assert property ((avs_read_i || avs_write_i) |-> ##[0:300] !avs_waitrequest_o)
    else $error("bus request never answered");
  clr_width_a: assert property ($fell(clear_n_o) |-> !clear_n_o [*4])
    else $error("clear pulse too short");
  unl_width_a: assert property ($fell(unload_clock_in_o) |-> !unload_clock_in_o [*3])
    else $error("unload low too short");
  unl_oe_a: assert property ($fell(unload_clock_in_o) |-> $past(!output_enable_n_o, 4))
    else $error("data not enabled before pop");
  ld_hold_a: assert property ($rose(load_clock_first_o) |-> $stable(write_data_bit_o) [*8])
    else $error("write data moved around load edge");
  ld_width_a: assert property ($rose(load_clock_first_o) |-> load_clock_first_o [*3])
    else $error("load clock high too short");
  ld_gate_a: assert property (load_clock_first_o |-> load_clock_second_o)
    else $error("gate low while load clock high");
  clr_unl_a: assert property (!clear_n_o |-> unload_clock_in_o)
    else $error("unload not idle during clear");
endmodule
bind fh_top fh_top_chk u_chk (.mclk_i(mclk_i), .srst_i(srst_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o), .load_clock_first_o(load_clock_first_o),
  .load_clock_second_o(load_clock_second_o), .write_data_bit_o(write_data_bit_o),
  .unload_clock_in_o(unload_clock_in_o), .clear_n_o(clear_n_o), .output_enable_n_o(output_enable_n_o));

// File: tb/fh_dev_model.sv
// Behavioural model of the 16x5 asynchronous FIFO device.
// Assumes pins driven by the host controller; no clock of its own.
`timescale 1ns/10ps
module fh_dev_model (
  input wire load_clock_first_i,       // Load clock or gate
  input wire load_clock_second_i,      // Load clock or gate
  input wire [4:0] write_data_bit_i,   // Word in
  input wire unload_clock_in_i,        // Unload clock
  input wire clear_n_i,                // Clear, low
  input wire output_enable_n_i,        // Output enable, low
  output wire input_ready_o,           // Room left
  output wire output_ready_o,          // Word at output
  output logic last_slot_vacant_pulse_o, // Vacancy pulse, low
  output wire [4:0] read_data_bit_o    // Word out
);
  logic [4:0] mem[$]; // Stored words, oldest first
  logic [4:0] head = 5'h00; // Word at the output
  int cnt = 0; // Fill level
  initial last_slot_vacant_pulse_o = 1'b1;
  // Store a word unless full
  task load;
    begin
      if (cnt < 16) mem.push_back(write_data_bit_i);
      cnt = mem.size();
      head = mem[0];
    end
  endtask
  // Either input clocks while the other gates
  always @(posedge load_clock_first_i) if (load_clock_second_i) load();
  always @(posedge load_clock_second_i) if (load_clock_first_i) load();
  // Pop on unload rise, pulse when last slot frees
  always @(posedge unload_clock_in_i) if (cnt > 0) begin
    if (cnt == 16) fork begin last_slot_vacant_pulse_o = 1'b0; #20; last_slot_vacant_pulse_o = 1'b1; end join_none
    void'(mem.pop_front());
    cnt = mem.size();
    if (cnt > 0) head = mem[0];
  end
  // Clear empties the store
  always @(negedge clear_n_i) begin
    mem.delete();
    cnt = 0;
  end
  assign #55 input_ready_o = (cnt < 16);
  assign #60 output_ready_o = (cnt > 0) && unload_clock_in_i;
  // Released pins show the inverse, never a stale match
  assign read_data_bit_o = output_enable_n_i ? ~head : head;
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the FIFO host controller with a device model.
// Assumes the register map of fh_regs.vh and a queue model of the store.
`timescale 1ns/10ps
`include "fh_regs.vh"
module tb_top;
  logic mclk_i = 1'b0; // Clock
  logic srst_i = 1'b1; // Reset
  logic [2:0] b_adr = 3'h0; // Bus address
  logic b_rd = 1'b0, b_wr = 1'b0; // Bus strobes
  logic [31:0] b_wd = 32'h0, q; // Write data, read result
  wire [31:0] b_rdata;
  wire b_wait, lc1, lc2, unl, clr_n, oe_n, ir, ordy, vac_n;
  wire [4:0] wdat, rdat;
  int num_errors = 0, checked = 0, i;
  int model[$]; // Expected store contents
  always #5 mclk_i = ~mclk_i;
  fh_top dut (.mclk_i(mclk_i), .srst_i(srst_i), .avs_address_i(b_adr), .avs_read_i(b_rd), .avs_write_i(b_wr),
    .avs_writedata_i(b_wd), .avs_readdata_o(b_rdata), .avs_waitrequest_o(b_wait), .load_clock_first_o(lc1),
    .load_clock_second_o(lc2), .write_data_bit_o(wdat), .unload_clock_in_o(unl), .clear_n_o(clr_n),
    .output_enable_n_o(oe_n), .input_ready_i(ir), .output_ready_i(ordy), .last_slot_vacant_pulse_i(vac_n),
    .read_data_bit_i(rdat));
  fh_dev_model u_dev (.load_clock_first_i(lc1), .load_clock_second_i(lc2), .write_data_bit_i(wdat),
    .unload_clock_in_i(unl), .clear_n_i(clr_n), .output_enable_n_i(oe_n), .input_ready_o(ir),
    .output_ready_o(ordy), .last_slot_vacant_pulse_o(vac_n), .read_data_bit_o(rdat));
  // Compare and count
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    begin
      checked++;
      if (got !== exp) begin
        num_errors++;
        $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  // One Avalon transfer, held until waitrequest is low
  task bus(input logic w, input logic [2:0] a, input logic [31:0] d);
    int n;
    begin
      n = 0;
      @(posedge mclk_i);
      b_adr <= a;
      b_wr <= w;
      b_rd <= !w;
      b_wd <= d;
      // Waitrequest and read data are taken at the rising edge
      do begin
        @(posedge mclk_i);
        n++;
      end while (b_wait !== 1'b0 && n < 2000);
      q = b_rdata;
      b_wr <= 1'b0;
      b_rd <= 1'b0;
      if (n >= 2000) chk("bus_timeout", 32'h0, 32'h1);
    end
  endtask
  // Poll until the pin sequence is done
  task idle;
    int k;
    begin
      k = 0;
      do begin
        bus(1'b0, `FH_REG_STATUS, 32'h0);
        k++;
      end while (q[`FH_ST_BUSY] !== 1'b0 && k < 60);
      if (q[`FH_ST_BUSY] !== 1'b0) chk("idle_timeout", 32'h0, 32'h1);
    end
  endtask
  task stat(input logic [4:0] exp);
    begin
      bus(1'b0, `FH_REG_STATUS, 32'h0);
      chk("status", {27'h0, exp}, q & 32'h1f);
    end
  endtask
  task push(input logic [4:0] v);
    begin
      bus(1'b1, `FH_REG_WDATA, {27'h0, v});
      idle();
      if (model.size() < `FH_DEPTH) model.push_back(v);
    end
  endtask
  task pop;
    begin
      bus(1'b1, `FH_REG_CMD, 32'h1);
      idle();
      bus(1'b0, `FH_REG_RDATA, 32'h0);
      if (model.size() > 0) chk("rdata", model.pop_front(), q);
    end
  endtask
  task tally_and_finish;
    begin
      if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // Hang guard
  initial begin
    #400000;
    num_errors++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    i = $urandom(85);
    repeat (2) @(posedge mclk_i);
    srst_i <= 1'b0;
    // Let the device status pins settle through the synchronisers
    repeat (10) @(posedge mclk_i);
    bus(1'b0, 3'h5, 32'h0);
    chk("unmapped", 32'h0, q);
    stat(5'b00010);
    bus(1'b1, `FH_REG_CTRL, 32'h1);
    for (i = 0; i < 17; i++) push(5'($urandom));
    stat(5'b10100);
    bus(1'b1, `FH_REG_STATUS, 32'h18);
    pop();
    stat(5'b01110);
    repeat (15) pop();
    stat(5'b01010);
    bus(1'b1, `FH_REG_STATUS, 32'h18);
    pop();
    stat(5'b10010);
    bus(1'b1, `FH_REG_STATUS, 32'h18);
    for (i = 0; i < 3; i++) push(5'($urandom));
    bus(1'b1, `FH_REG_CMD, 32'h2);
    idle();
    model.delete();
    stat(5'b00010);
    bus(1'b1, `FH_REG_CTRL, 32'h0);
    push(5'($urandom));
    stat(5'b00110);
    pop();
    tally_and_finish();
  end
endmodule
